// File: hdl/bpc_header_front.sv
// Three-port configuration header front: identification and command
//
// Contract
// - Three ports, each with independent register copies
// - Offset zero returns fixed read-only maker word
// - Offset two returns fixed read-only part word
// - Bit 0 gates I/O window decode
// - Bit 1 gates memory and prefetch decode
// - Bit 2 gates upstream memory/IO request forwarding
// - Forwarding off: non-posted gets Unsupported Request
// - Completions and other requests always pass
// - Bit 6 lets poison set parity flag
// - Bit 6 clear: parity flag never set
// - Bit 8 or device-control enables report errors
// - Bit 10 suppresses own legacy interrupts
// - Unused command bits read zero, read-only
// - Status bit 8 parity flag, write-one clear
// - Status bit 14 error-sent flag, write-one clear
`timescale 1ns/1ps
`include "bpc_consts.svh"

// ****************************************************************
// Ports and parameters
// ****************************************************************
module bpc_header_front
   import bpc_pkg::*;
#(
   parameter int          NPORTS   = `BPC_NUM_PORTS,
   parameter logic [15:0] MAKER_ID = 16'h5a5a, // Arbitrary value
   parameter logic [15:0] PART_ID  = 16'ha5a5  // Arbitrary value
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // Configuration access, one dword, port selected by cfg_port
   input  wire logic                cfg_wr,
   input  wire logic                cfg_rd,
   input  wire logic [1:0]          cfg_port,
   input  wire logic [11:0]         cfg_addr,
   input  wire logic [3:0]          cfg_be,
   input  wire logic [31:0]         cfg_wdata,
   output logic      [31:0]         cfg_rdata,
   output logic                     cfg_rvalid,
   // Primary-side decode hits per port
   input  wire logic [NPORTS-1:0]   io_win_hit,
   input  wire logic [NPORTS-1:0]   mem_win_hit,
   output logic      [NPORTS-1:0]   io_claim,
   output logic      [NPORTS-1:0]   mem_claim,
   // Requests from below, per port
   input  wire logic [NPORTS-1:0]   req_valid,
   input  wire logic [2*NPORTS-1:0] req_kind,
   input  wire logic [NPORTS-1:0]   req_nonposted,
   output logic      [NPORTS-1:0]   req_forward,
   output logic      [NPORTS-1:0]   req_ur,
   // Errors and interrupts per port
   input  wire logic [NPORTS-1:0]   poison_rx,
   input  wire logic [NPORTS-1:0]   err_detect,
   input  wire logic [NPORTS-1:0]   devctl_err_en,
   input  wire logic [NPORTS-1:0]   irq_req,
   output logic      [NPORTS-1:0]   err_msg_send,
   output logic      [NPORTS-1:0]   legacy_irq
);

   // ****************************************************************
   // Per-port wiring
   // ****************************************************************
   logic [31:0]       rd_port [NPORTS];
   logic [15:0]       cmd     [NPORTS];
   logic [NPORTS-1:0] port_sel;
   logic [NPORTS-1:0] port_wr;
   logic [31:0]       rd_mux;

   // ****************************************************************
   // Request decode helpers
   // ****************************************************************
   // Only memory and I/O requests are gated by the enable
   function automatic logic gated_kind(
      input logic [1:0] k
   );
      gated_kind = (k == BPC_TLP_MEM) || (k == BPC_TLP_IO);
   endfunction : gated_kind

   // Completions and non-mem/io requests bypass the enable
   function automatic logic may_forward(
      input logic       valid,
      input logic [1:0] k,
      input logic       fwd_en
   );
      may_forward = valid && (!gated_kind(k) || fwd_en);
   endfunction : may_forward

   // Posted writes are dropped silently; only non-posted get UR
   function automatic logic owes_ur(
      input logic       valid,
      input logic [1:0] k,
      input logic       nonposted,
      input logic       fwd_en
   );
      owes_ur = valid && gated_kind(k) && nonposted && !fwd_en;
   endfunction : owes_ur

   // Either enable lets a detected error go out as a message
   function automatic logic may_report(
      input logic detect,
      input logic cmd_en,
      input logic devctl_en
   );
      may_report = detect && (cmd_en || devctl_en);
   endfunction : may_report

   // A window hit is claimed only while its space is enabled
   function automatic logic may_claim(
      input logic hit,
      input logic space_en
   );
      may_claim = hit && space_en;
   endfunction : may_claim

   // The disable silences only interrupts raised by this port
   function automatic logic may_interrupt(
      input logic request,
      input logic disable_bit
   );
      may_interrupt = request && !disable_bit;
   endfunction : may_interrupt

   // ****************************************************************
   // Configuration port select
   // ****************************************************************
   // Port code 3 selects nothing, so its writes vanish and reads give 0
   always_comb begin
      port_sel = '0;
      for (int q = 0; q < NPORTS; q++) begin
         if (cfg_port == 2'(q))
            port_sel[q] = 1'b1;
      end
   end

   assign port_wr = port_sel & {NPORTS{cfg_wr}};

   // A one-hot mux avoids indexing past the last port
   always_comb begin
      rd_mux = 32'h0000_0000;
      for (int q = 0; q < NPORTS; q++) begin
         if (port_sel[q])
            rd_mux = rd_port[q];
      end
   end

   // ****************************************************************
   // Per-port registers and gating
   // ****************************************************************
   // Independent copy per port
   for (genvar p = 0; p < NPORTS; p++) begin : g_port
      logic [1:0] kind;

      bpc_port_regs #(
         .MAKER_ID (MAKER_ID),
         .PART_ID  (PART_ID)
      ) u_regs (
         .clk          (clk),
         .resetn       (resetn),
         .cfg_wr       (port_wr[p]),
         .cfg_addr     (cfg_addr),
         .cfg_be       (cfg_be),
         .cfg_wdata    (cfg_wdata),
         .cfg_rdata    (rd_port[p]),
         .poison_rx    (poison_rx[p]),
         .err_msg_sent (err_msg_send[p]),
         .command      (cmd[p])
      );

      assign kind = req_kind[2*p +: 2];

      // Primary-side window claims
      assign io_claim[p]  = may_claim(io_win_hit[p],
                                      cmd[p][`BPC_CMD_IO_EN]);
      assign mem_claim[p] = may_claim(mem_win_hit[p],
                                      cmd[p][`BPC_CMD_MEM_EN]);

      // Requests from below
      assign req_forward[p] = may_forward(req_valid[p], kind,
                                          cmd[p][`BPC_CMD_FWD_EN]);
      assign req_ur[p] = owes_ur(req_valid[p], kind, req_nonposted[p],
                                 cmd[p][`BPC_CMD_FWD_EN]);

      // Error messages and legacy interrupts
      assign err_msg_send[p] = may_report(err_detect[p],
                                          cmd[p][`BPC_CMD_FATAL_EN],
                                          devctl_err_en[p]);
      assign legacy_irq[p] = may_interrupt(irq_req[p],
                                           cmd[p][`BPC_CMD_IRQ_DIS]);
   end

   // ****************************************************************
   // Read return
   // ****************************************************************
   // Read answer one cycle after the request, from a flip-flop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         cfg_rvalid <= 1'b0;
      else
         cfg_rvalid <= cfg_rd;
   end

   // Data falls back to zero so a stale word never lingers on the bus
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         cfg_rdata <= 32'h0000_0000;
      else if (cfg_rd)
         cfg_rdata <= rd_mux;
      else
         cfg_rdata <= 32'h0000_0000;
   end
endmodule : bpc_header_front

// File: hdl/bpc_consts.svh
// Constants for the bridge port configuration header front block
`ifndef BPC_CONSTS_SVH
`define BPC_CONSTS_SVH
`define BPC_NUM_PORTS       3
`define BPC_OFF_MAKER_ID    12'h000
`define BPC_OFF_PART_ID     12'h002
`define BPC_OFF_COMMAND     12'h004
`define BPC_OFF_STATUS      12'h006
`define BPC_CMD_IO_EN       0
`define BPC_CMD_MEM_EN      1
`define BPC_CMD_FWD_EN      2
`define BPC_CMD_POISON_EN   6
`define BPC_CMD_FATAL_EN    8
`define BPC_CMD_IRQ_DIS     10
`define BPC_CMD_RW_MASK     16'h0547
`define BPC_CMD_RESET       16'h0000
`define BPC_STS_MDPE        8
`define BPC_STS_SSE         14
`define BPC_STS_RESET       16'h0000
`endif

// File: hdl/bpc_pkg.sv
// Types for the bridge port configuration header front block
package bpc_pkg;
   typedef enum logic [1:0] {
      BPC_TLP_MEM   = 2'b00,
      BPC_TLP_IO    = 2'b01,
      BPC_TLP_CPL   = 2'b10,
      BPC_TLP_OTHER = 2'b11
   } bpc_tlp_kind_t;
endpackage : bpc_pkg

// File: hdl/bpc_port_regs.sv
// One port's identification, command and status registers
`timescale 1ns/1ps
`include "bpc_consts.svh"
module bpc_port_regs
   import bpc_pkg::*;
#(
   parameter logic [15:0] MAKER_ID = 16'h5a5a, // Arbitrary value
   parameter logic [15:0] PART_ID  = 16'ha5a5  // Arbitrary value
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Configuration access
   input  wire logic        cfg_wr,
   input  wire logic [11:0] cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   // Status events
   input  wire logic        poison_rx,
   input  wire logic        err_msg_sent,
   // Command
   output logic      [15:0] command
);
   logic [15:0] cmd_reg;
   logic [15:0] sts_reg;
   logic        dw0;
   logic        dw1;
   logic [15:0] mask;
   logic [15:0] w1c;

   assign dw0 = (cfg_addr[11:2] == 10'(`BPC_OFF_MAKER_ID >> 2));
   assign dw1 = (cfg_addr[11:2] == 10'(`BPC_OFF_COMMAND >> 2));
   assign mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
   assign w1c = (cfg_wr && dw1) ? (cfg_wdata[31:16] &
                {{8{cfg_be[3]}}, {8{cfg_be[2]}}}) : 16'h0000;

   // Only writable bits move, only in enabled lanes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         cmd_reg <= `BPC_CMD_RESET;
      else if (cfg_wr && dw1)
         cmd_reg <= (cmd_reg & ~(mask & `BPC_CMD_RW_MASK)) |
                    (cfg_wdata[15:0] & mask & `BPC_CMD_RW_MASK);
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         sts_reg <= `BPC_STS_RESET;
      else begin
         sts_reg[`BPC_STS_MDPE] <= (poison_rx &&
            cmd_reg[`BPC_CMD_POISON_EN]) ||
            (sts_reg[`BPC_STS_MDPE] && !w1c[`BPC_STS_MDPE]);
         sts_reg[`BPC_STS_SSE] <= (err_msg_sent &&
            cmd_reg[`BPC_CMD_FATAL_EN]) ||
            (sts_reg[`BPC_STS_SSE] && !w1c[`BPC_STS_SSE]);
      end
   end

   // Identification words are constants; writes have no path to them
   always_comb begin
      if (dw0)
         cfg_rdata = {PART_ID, MAKER_ID};
      else if (dw1)
         cfg_rdata = {sts_reg & 16'h4100, cmd_reg & `BPC_CMD_RW_MASK};
      else
         cfg_rdata = 32'h0000_0000;
   end

   assign command = cmd_reg;
endmodule : bpc_port_regs

// File: sim/bpc_rc_model.sv
// Root complex model issuing configuration accesses
`timescale 1ns/1ps
module bpc_rc_model (
   // Clock and request
   input  wire logic        clk,
   output logic             cfg_wr,
   output logic             cfg_rd,
   output logic      [1:0]  cfg_port,
   output logic      [11:0] cfg_addr,
   output logic      [3:0]  cfg_be,
   output logic      [31:0] cfg_wdata
);
   initial {cfg_wr, cfg_rd, cfg_port, cfg_addr, cfg_be, cfg_wdata} = '0;
   // Held over one rising edge, then released with both strobes low and address and data inverted
   task automatic acc(input logic w, input logic [1:0] p,
      input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
      @(negedge clk);
      {cfg_wr, cfg_rd, cfg_port, cfg_addr, cfg_be} = {w, !w, p, a, b};
      cfg_wdata = d;
      @(negedge clk);
      {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'b00, ~a, ~d};
   endtask : acc
endmodule : bpc_rc_model

// File: sim/bpc_header_front_monitor.sv
// Port checks for the header front
`timescale 1ns/1ps
module bpc_header_front_monitor #(parameter int NPORTS = 3) (
   input wire logic                clk, resetn, cfg_rd, cfg_rvalid,
   input wire logic [31:0]         cfg_rdata,
   input wire logic [NPORTS-1:0]   io_win_hit, mem_win_hit, io_claim,
   mem_claim, req_valid, req_nonposted, req_forward, req_ur, err_detect,
   devctl_err_en, irq_req, err_msg_send, legacy_irq,
   input wire logic [2*NPORTS-1:0] req_kind
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_rd_answer: assert property (cfg_rvalid == $past(cfg_rd))
      else $error("read answer timing wrong");
   chk_rdata_idle: assert property (!cfg_rvalid |-> cfg_rdata == 0)
      else $error("read data stands too long");
   chk_io_gate: assert property ((io_claim & ~io_win_hit) == 0)
      else $error("io claim without hit");
   chk_mem_gate: assert property ((mem_claim & ~mem_win_hit) == 0)
      else $error("mem claim without hit");
   chk_fwd_excl: assert property ((req_forward & req_ur) == 0)
      else $error("forward and UR together");
   chk_ur_cause: assert property ((req_ur & ~req_nonposted) == 0)
      else $error("UR on posted request");
   chk_cpl_pass: assert property (req_valid[0] && req_kind[1]
      |-> req_forward[0]) else $error("completion not forwarded");
   chk_err_report: assert property
      ((err_detect & devctl_err_en & ~err_msg_send) == 0)
      else $error("error not reported");
   chk_irq_gate: assert property ((legacy_irq & ~irq_req) == 0)
      else $error("interrupt without request");
   cover property (cfg_rvalid);
   cover property (|req_ur);
   cover property (|err_msg_send);
endmodule : bpc_header_front_monitor
bind bpc_header_front bpc_header_front_monitor #(.NPORTS(NPORTS)) u_mon (.*);

// File: sim/bpc_header_front_bench.sv
// Self-checking bench for the three-port header front
`timescale 1ns/1ps
`include "bpc_consts.svh"
module bpc_header_front_bench;
   import bpc_pkg::*;
   logic clk = 0, resetn = 0, cfg_wr, cfg_rd, cfg_rvalid;
   logic [1:0] cfg_port;
   logic [11:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata;
   logic [2:0] io_win_hit = 0, mem_win_hit = 0, req_valid = 0;
   logic [2:0] req_nonposted = 0, poison_rx = 0, err_detect = 0;
   logic [2:0] devctl_err_en = 0, irq_req = 0, io_claim, mem_claim;
   logic [2:0] req_forward, req_ur, err_msg_send, legacy_irq, e[6];
   logic [5:0] req_kind = 0;
   int errors = 0, cmp_count = 0, cmd_m[4], sts_m[4];
   bpc_header_front u_dut (.*);
   bpc_rc_model u_rc (.*);
   always #50 clk = ~clk;
   task automatic chk_rd(string n, logic [31:0] x, logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         errors++;
         $display("mismatch %s exp %h got %h", n, x, g);
      end
   endtask : chk_rd
   task automatic chk_pin(string n, logic [2:0] x, logic [2:0] g);
      chk_rd(n, {29'h0, x}, {29'h0, g});
   endtask : chk_pin
   task automatic rd(logic [1:0] p, logic [11:0] a, logic [31:0] x);
      u_rc.acc(0, p, a, 4'hf, 0);
      chk_rd("rvalid", 32'h1, {31'h0, cfg_rvalid});
      chk_rd("rdata", x, cfg_rdata);
   endtask : rd
   task automatic summarize();
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      void'($urandom(32'hc535));
      repeat (4) @(negedge clk);
      resetn = 1;
      for (int p = 0; p < 4; p++) begin
         rd(p, 12'h004, 0);
         u_rc.acc(1, p, 12'h000, 4'hf, $urandom);
         rd(p, 12'h000, p < 3 ? 32'ha5a55a5a : 0);
      end
      rd(0, 12'h008, 0);
      $display("test ident done");
      for (int i = 0; i < 60; i++) begin
         logic [1:0] p;
         logic [3:0] b;
         logic [31:0] d, m;
         p = 2'($urandom_range(3));
         b = 4'($urandom);
         d = $urandom;
         {io_win_hit, mem_win_hit, req_valid, req_nonposted, poison_rx,
            err_detect, devctl_err_en, irq_req, req_kind} = 30'($urandom);
         #1;
         for (int q = 0; q < 3; q++) begin
            e[0][q] = io_win_hit[q] & cmd_m[q][0];
            e[1][q] = mem_win_hit[q] & cmd_m[q][1];
            e[2][q] = req_valid[q] & (req_kind[2*q+1] | cmd_m[q][2]);
            e[3][q] = req_valid[q] & ~req_kind[2*q+1] & req_nonposted[q]
               & !cmd_m[q][2];
            e[4][q] = err_detect[q] & (cmd_m[q][8] | devctl_err_en[q]);
            e[5][q] = irq_req[q] & !cmd_m[q][10];
            if (poison_rx[q] & cmd_m[q][6]) sts_m[q] |= 'h100;
            if (e[4][q] & cmd_m[q][8]) sts_m[q] |= 'h4000;
         end
         chk_pin("io_claim", e[0], io_claim);
         chk_pin("mem_claim", e[1], mem_claim);
         chk_pin("req_forward", e[2], req_forward);
         chk_pin("req_ur", e[3], req_ur);
         chk_pin("err_msg_send", e[4], err_msg_send);
         chk_pin("legacy_irq", e[5], legacy_irq);
         @(negedge clk);
         {poison_rx, err_detect} = 0;
         u_rc.acc(1, p, 12'h004, b, d);
         m = `BPC_CMD_RW_MASK & {{8{b[1]}}, {8{b[0]}}};
         cmd_m[p] = (cmd_m[p] & ~m) | (d & m);
         if (b[3]) sts_m[p] &= ~(d[31:16] & 'h4100);
         rd(p, 12'h004, p > 2 ? 0 : {sts_m[p][15:0], cmd_m[p][15:0]});
      end
      $display("test command done");
      summarize();
   end
   // Run is a few hundred cycles; the limit leaves wide margin
   initial begin
      #1ms;
      errors++;
      summarize();
   end
endmodule : bpc_header_front_bench
